// *** hdl/icp_i2c_config_port.sv ***
`timescale 1ns/1ps
`default_nettype none
module icp_i2c_config_port
  import icp_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  input  wire logic        select_pin_lsb,
  input  wire logic        select_pin_second,
  input  wire logic        select_pin_third,
  input  wire logic        select_pin_msb,
  input  wire logic [3:0]  nvm_control_code,
  input  wire logic [3:0]  nvm_pin_select,
  input  wire logic        nvm_port_disable,
  input  wire logic        nvm_prog_disable,
  input  wire logic        nvm_code_compare,
  input  wire logic        nvm_prot_enable,
  input  wire logic [2:0]  nvm_prot_mode,
  input  wire logic [55:0] live_values,
  input  wire logic [15:0] counter_macrocell_wide,
  input  wire logic [7:0]  counter_macrocell_a,
  input  wire logic [7:0]  counter_macrocell_b,
  input  wire logic        por_restart_done,
  output logic             por_restart_req,
  output logic             outputs_frozen,
  output logic [7:0]       virtual_inputs,
  output logic             cfg_wr_valid,
  output logic [7:0]       cfg_wr_addr,
  output logic [7:0]       cfg_wr_data
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [1:0] scl_s;
  logic [1:0] sda_s;
  logic [1:0] sel_s [4];
  logic       scl_d;
  logic       sda_d;
  logic       scl;
  logic       sda;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_det;
  logic       stop_det;
  logic [3:0] chip_code;
  icp_state_e state_reg;
  logic [3:0] cnt_reg;
  logic [7:0] sr_reg;
  logic [7:0] txb_reg;
  logic       oe_reg;
  logic       rw_reg;
  logic       blk_bad_reg;
  logic       wr_seen_reg;
  logic       writing_reg;
  logic [7:0] wa_reg;
  logic [7:0] last_reg;
  logic [7:0] ptr_reg;
  logic [7:0] mem [256];
  logic [7:0] mask_reg;
  logic       cmd_set_mask_reg;
  logic       sreset_reg;
  logic       latch_reg;
  logic [2:0] mode_reg;
  logic       load_pend_reg;
  logic [7:0] vin_reg;
  logic       frozen_reg;
  logic [2:0] mode_eff;
  icp_group_e grp;
  logic       rd_ok;
  logic       wr_ok;
  logic       ctl_rd;
  logic       ctl_wr;
  logic [7:0] raw_byte;
  logic [7:0] rd_byte;
  logic [7:0] wdata_eff;
  logic       wr_fire;
  logic [2:0] live_idx;

  // ----------------------------------------------------------------
  // Input synchronisers and bus events
  // ----------------------------------------------------------------
  // Two stages on every pin input
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      scl_s <= 2'h3;
      sda_s <= 2'h3;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_s <= {scl_s[0], scl_i};
      sda_s <= {sda_s[0], sda_i};
      scl_d <= scl_s[1];
      sda_d <= sda_s[1];
    end
  end

  // Select pins share the same double stage
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < 4; i++) begin
        sel_s[i] <= 2'h0;
      end
    end else begin
      sel_s[0] <= {sel_s[0][0], select_pin_lsb};
      sel_s[1] <= {sel_s[1][0], select_pin_second};
      sel_s[2] <= {sel_s[2][0], select_pin_third};
      sel_s[3] <= {sel_s[3][0], select_pin_msb};
    end
  end

  // Edges and start/stop conditions
  assign scl       = scl_s[1];
  assign sda       = sda_s[1];
  assign scl_rise  = scl & ~scl_d;
  assign scl_fall  = ~scl & scl_d;
  assign start_det = scl & scl_d & sda_d & ~sda;
  assign stop_det  = scl & scl_d & ~sda_d & sda;

  // Per-bit code source: pin or stored bit
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      chip_code[i] = nvm_pin_select[i] ? sel_s[i][1]
                                       : nvm_control_code[i]; // [R2]
    end
  end

  // ----------------------------------------------------------------
  // Access decode
  // ----------------------------------------------------------------
  // Mode counts only when protection is enabled
  assign mode_eff = nvm_prot_enable ? mode_reg : MODE_OPEN; // [R13]

  // Address to access group
  always_comb begin
    if (wa_reg == ADDR_VIRT_IN || wa_reg == ADDR_WR_MASK) begin
      grp = GRP_CTL;
    end else if (wa_reg <= ADDR_ROUTE_LAST) begin
      grp = GRP_ROUTE;
    end else if (wa_reg >= ADDR_LIVE_FIRST && wa_reg <= ADDR_LIVE_LAST) begin
      grp = GRP_LIVE;
    end else if (wa_reg >= ADDR_CNT16_LO && wa_reg <= ADDR_CNT8_B) begin
      grp = GRP_LIVE;
    end else if (wa_reg == ADDR_CODE_CFG || wa_reg == ADDR_PORT_CTRL) begin
      grp = GRP_FIXED;
    end else if (wa_reg == ADDR_PROT_CTRL) begin
      grp = GRP_PROT;
    end else begin
      grp = GRP_CFG;
    end
  end

  // Read and write permission per mode
  always_comb begin
    ctl_rd = RD_CTL[mode_eff];                        // [R14]
    ctl_wr = WR_CTL[mode_eff];                        // [R14]
    case (grp)
      GRP_CTL:   begin rd_ok = ctl_rd; wr_ok = ctl_wr; end
      GRP_CFG:   begin
        rd_ok = RD_CFG[mode_eff];                     // [R15]
        wr_ok = WR_CFG[mode_eff];                     // [R15]
      end
      GRP_ROUTE: begin
        rd_ok = RD_ROUTE[mode_eff];                   // [R16]
        wr_ok = WR_ROUTE[mode_eff];                   // [R16]
      end
      GRP_LIVE:  begin
        rd_ok = RD_LIVE[mode_eff];                    // [R17]
        wr_ok = NONE[mode_eff];                       // [R22]
      end
      GRP_FIXED: begin
        rd_ok = RD_ALL[mode_eff];                     // [R18]
        wr_ok = NONE[mode_eff];                       // [R18]
      end
      default:   begin rd_ok = RD_ALL[mode_eff]; wr_ok = 1'b1; end
    endcase
    if (blk_bad_reg) begin
      rd_ok = 1'b0;                                   // [R4]
      wr_ok = 1'b0;                                   // [R4]
    end
  end

  // Live slot index skipping the virtual input byte
  assign live_idx = wa_reg[2] ? wa_reg[2:0] - 3'h1 : wa_reg[2:0];

  // Stored or live value at the working address
  always_comb begin
    if (wa_reg == ADDR_VIRT_IN) begin
      raw_byte = vin_reg;
    end else if (wa_reg == ADDR_WR_MASK) begin
      raw_byte = mask_reg;
    end else if (wa_reg >= ADDR_LIVE_FIRST && wa_reg <= ADDR_LIVE_LAST) begin
      raw_byte = live_values[8*live_idx +: 8];        // [R19]
    end else if (wa_reg == ADDR_CNT16_LO) begin
      raw_byte = counter_macrocell_wide[7:0];         // [R17]
    end else if (wa_reg == ADDR_CNT16_HI) begin
      raw_byte = counter_macrocell_wide[15:8];        // [R17]
    end else if (wa_reg == ADDR_CNT8_A) begin
      raw_byte = counter_macrocell_a;                 // [R17]
    end else if (wa_reg == ADDR_CNT8_B) begin
      raw_byte = counter_macrocell_b;                 // [R17]
    end else if (wa_reg == ADDR_PROT_CTRL) begin
      raw_byte = {mode_reg, 1'b0, nvm_prot_enable, 1'b0,
                  latch_reg & ctl_rd, sreset_reg & ctl_rd}; // [R13]
    end else if (wa_reg == ADDR_CODE_CFG) begin
      raw_byte = {nvm_pin_select, nvm_control_code};  // [R18]
    end else if (wa_reg == ADDR_PORT_CTRL) begin
      raw_byte = {5'h00, nvm_code_compare, nvm_prog_disable,
                  nvm_port_disable};                  // [R18]
    end else begin
      raw_byte = mem[wa_reg];
    end
  end

  assign rd_byte = rd_ok ? raw_byte : 8'h00;

  // Masked bits keep their old value
  assign wdata_eff = (mask_reg != MASK_RESET && !cmd_set_mask_reg)
                     ? ((raw_byte & mask_reg) | (sr_reg & ~mask_reg))
                     : sr_reg;                        // [R21]

  // Data byte commit at the acknowledge edge
  assign wr_fire = (state_reg == S_WDATA) && scl_fall
                   && (cnt_reg == BYTE_BITS);         // [R6]

  // ----------------------------------------------------------------
  // Protocol engine
  // ----------------------------------------------------------------
  // Bit shifting, acknowledge and address pointer
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg   <= S_IDLE;
      cnt_reg     <= 4'h0;
      sr_reg      <= 8'h00;
      txb_reg     <= 8'h00;
      oe_reg      <= 1'b0;
      rw_reg      <= 1'b0;
      blk_bad_reg <= 1'b0;
      wr_seen_reg <= 1'b0;
      writing_reg <= 1'b0;
      wa_reg      <= 8'h00;
      last_reg    <= 8'h00;
      ptr_reg     <= 8'h00;
    end else if (start_det) begin
      state_reg   <= S_CTRL;                          // [R1]
      cnt_reg     <= 4'h0;
      oe_reg      <= 1'b0;
      writing_reg <= 1'b0;                            // [R11]
    end else if (stop_det) begin
      state_reg   <= S_IDLE;
      oe_reg      <= 1'b0;
      writing_reg <= 1'b0;
      wr_seen_reg <= 1'b0;
      if (wr_seen_reg) begin
        ptr_reg <= last_reg + 8'h01;                  // [R9]
        wa_reg  <= last_reg + 8'h01;                  // [R9]
      end else begin
        wa_reg  <= ptr_reg;                           // [R10]
      end
    end else begin
      case (state_reg)
        S_CTRL, S_ADDR, S_WDATA: begin
          if (scl_rise && cnt_reg != BYTE_BITS) begin
            sr_reg  <= {sr_reg[6:0], sda};
            cnt_reg <= cnt_reg + 4'h1;
          end else if (scl_fall && cnt_reg == BYTE_BITS) begin
            cnt_reg <= 4'h0;
            oe_reg  <= 1'b1;
            if (state_reg == S_CTRL) begin
              if (nvm_port_disable || sr_reg[7:4] != chip_code) begin
                state_reg <= S_IDLE;                  // [R23]
                oe_reg    <= 1'b0;                    // [R23]
              end else begin
                state_reg   <= S_CACK;                // [R3]
                rw_reg      <= sr_reg[0];             // [R1]
                blk_bad_reg <= sr_reg[3:1] != 3'h0;   // [R4]
                if (!sr_reg[0]) begin
                  wr_seen_reg <= 1'b1;                // [R9]
                  writing_reg <= 1'b1;                // [R7]
                end
              end
            end else if (state_reg == S_ADDR) begin
              wa_reg    <= sr_reg;                    // [R5]
              last_reg  <= sr_reg;
              state_reg <= S_AACK;
            end else begin
              last_reg  <= wa_reg;
              wa_reg    <= wa_reg + 8'h01;            // [R8]
              state_reg <= S_WACK;                    // [R6]
            end
          end
        end
        S_CACK: begin
          if (scl_fall) begin
            if (rw_reg) begin
              txb_reg   <= rd_byte;                   // [R10]
              oe_reg    <= ~rd_byte[7];
              state_reg <= S_RDATA;
            end else begin
              oe_reg    <= 1'b0;
              state_reg <= S_ADDR;                    // [R5]
            end
          end
        end
        S_AACK, S_WACK: begin
          if (scl_fall) begin
            oe_reg    <= 1'b0;
            state_reg <= S_WDATA;
          end
        end
        S_RDATA: begin
          if (scl_rise) begin
            cnt_reg <= cnt_reg + 4'h1;
          end else if (scl_fall) begin
            if (cnt_reg == BYTE_BITS) begin
              cnt_reg   <= 4'h0;
              oe_reg    <= 1'b0;
              last_reg  <= wa_reg;
              wa_reg    <= wa_reg + 8'h01;            // [R12]
              state_reg <= S_RACK;
            end else begin
              txb_reg <= {txb_reg[6:0], 1'b0};
              oe_reg  <= ~txb_reg[6];
            end
          end
        end
        S_RACK: begin
          if (scl_rise && sda) begin
            state_reg <= S_IDLE;                      // [R10]
          end else if (scl_fall) begin
            txb_reg   <= rd_byte;                     // [R12]
            oe_reg    <= ~rd_byte[7];
            state_reg <= S_RDATA;
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // Open drain: only ever pull low
  assign sda_o  = 1'b0;
  assign sda_oe = oe_reg;

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  // Configuration and routing storage
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < 256; i++) begin
        mem[i] <= 8'h00;
      end
    end else if (wr_fire && wr_ok
                 && (grp == GRP_CFG || grp == GRP_ROUTE)) begin
      mem[wa_reg] <= wdata_eff;                       // [R6]
    end
  end

  // Strobe towards the macrocells
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_wr_valid <= 1'b0;
      cfg_wr_addr  <= 8'h00;
      cfg_wr_data  <= 8'h00;
    end else begin
      cfg_wr_valid <= wr_fire && wr_ok
                      && (grp == GRP_CFG || grp == GRP_ROUTE);
      if (wr_fire && wr_ok && (grp == GRP_CFG || grp == GRP_ROUTE)) begin
        cfg_wr_addr <= wa_reg;
        cfg_wr_data <= wdata_eff;
      end
    end
  end

  // Virtual inputs accept writes
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      vin_reg <= 8'h00;
    end else if (wr_fire && wr_ok && wa_reg == ADDR_VIRT_IN) begin
      vin_reg <= wdata_eff;                           // [R22]
    end
  end

  assign virtual_inputs = vin_reg;

  // Byte write mask: armed, used once, or discarded
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mask_reg         <= MASK_RESET;
      cmd_set_mask_reg <= 1'b0;
    end else if (wr_fire && wr_ok && wa_reg == ADDR_WR_MASK) begin
      mask_reg         <= sr_reg;                     // [R21]
      cmd_set_mask_reg <= 1'b1;
    end else if (wr_fire && !cmd_set_mask_reg) begin
      mask_reg <= MASK_RESET;                         // [R21]
    end else if (stop_det) begin
      cmd_set_mask_reg <= 1'b0;
      if (!cmd_set_mask_reg) begin
        mask_reg <= MASK_RESET;                       // [R21]
      end
    end
  end

  // Protection mode, loaded once after reset
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_reg      <= MODE_OPEN;
      load_pend_reg <= 1'b1;
    end else if (load_pend_reg) begin
      mode_reg      <= nvm_prot_mode;
      load_pend_reg <= 1'b0;
    end else if (wr_fire && wa_reg == ADDR_PROT_CTRL && !blk_bad_reg
                 && mode_eff == MODE_OPEN) begin
      mode_reg <= wdata_eff[7:5];                     // [R13]
    end
  end

  // Latch enable and serial reset bits
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      latch_reg  <= 1'b0;
      sreset_reg <= 1'b0;
    end else begin
      if (wr_fire && wa_reg == ADDR_PROT_CTRL && !blk_bad_reg && ctl_wr) begin
        latch_reg <= wdata_eff[BIT_LATCH];            // [R14]
      end
      if (wr_fire && wa_reg == ADDR_PROT_CTRL && !blk_bad_reg && ctl_wr
          && wdata_eff[BIT_SRESET]) begin
        sreset_reg <= 1'b1;                           // [R20]
      end else if (por_restart_done) begin
        sreset_reg <= 1'b0;                           // [R20]
      end
    end
  end

  assign por_restart_req = sreset_reg;

  // Output freeze during a write command
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      frozen_reg <= 1'b0;
    end else begin
      frozen_reg <= writing_reg & (latch_reg | frozen_reg); // [R7]
    end
  end

  assign outputs_frozen = frozen_reg;

endmodule
`default_nettype wire

// *** pkg/icp_pkg.sv ***
// Behaviour
// (R1) Control byte: code, block bits, read flag
// (R2) Code bits from register or pin per select
// (R3) Acknowledge a received control byte
// (R4) Eleven-bit address, only 0x00-0xFF valid
// (R5) Word address follows control byte except current-read
// (R6) Byte write commits at data acknowledge
// (R7) Latch enable freezes outputs during writes
// (R8) Sequential write advances address per byte
// (R9) Pointer increments at stop after write control
// (R10) Current read returns byte at pointer
// (R11) Repeated start keeps loaded address
// (R12) Master acknowledge requests next read byte
// (R13) Eight modes; mode field writable in mode 0
// (R14) Control group access per mode
// (R15) Configuration bits access per mode
// (R16) Routing registers access per mode
// (R17) Live values and counters readable per mode
// (R18) Code and port control always read-only
// (R19) Live matrix inputs readable as registers
// (R20) Serial reset bit restarts power-on, self-clears
// (R21) Mask protects bits on next byte write
// (R22) Writes to live values ignored except virtual
// (R23) Acknowledge only on matching chip code
package icp_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_ROUTE_LAST = 8'h47;
  localparam logic [7:0] ADDR_LIVE_FIRST = 8'h48;
  localparam logic [7:0] ADDR_VIRT_IN    = 8'h4c;
  localparam logic [7:0] ADDR_LIVE_LAST  = 8'h4f;
  localparam logic [7:0] ADDR_CNT16_LO   = 8'ha5;
  localparam logic [7:0] ADDR_CNT16_HI   = 8'ha6;
  localparam logic [7:0] ADDR_CNT8_A     = 8'ha7;
  localparam logic [7:0] ADDR_CNT8_B     = 8'ha8;
  localparam logic [7:0] ADDR_PROT_CTRL  = 8'hf5;
  localparam logic [7:0] ADDR_WR_MASK    = 8'hf6;
  localparam logic [7:0] ADDR_CODE_CFG   = 8'hfd;
  localparam logic [7:0] ADDR_PORT_CTRL  = 8'hfe;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int         BIT_SRESET   = 0;
  localparam int         BIT_LATCH    = 1;
  localparam logic [3:0] BYTE_BITS    = 4'h8;
  localparam logic [7:0] MASK_RESET   = 8'h00;
  localparam logic [2:0] MODE_OPEN    = 3'h0;

  // ----------------------------------------------------------------
  // Access masks, bit m set when mode m allows it
  // ----------------------------------------------------------------
  localparam logic [7:0] RD_CTL   = 8'h2f;
  localparam logic [7:0] WR_CTL   = 8'h1f;
  localparam logic [7:0] RD_CFG   = 8'h23;
  localparam logic [7:0] WR_CFG   = 8'h17;
  localparam logic [7:0] RD_ROUTE = 8'h21;
  localparam logic [7:0] WR_ROUTE = 8'h17;
  localparam logic [7:0] RD_LIVE  = 8'h2f;
  localparam logic [7:0] RD_ALL   = 8'hff;
  localparam logic [7:0] NONE     = 8'h00;

  typedef enum logic [2:0] {
    GRP_CTL, GRP_CFG, GRP_ROUTE, GRP_LIVE, GRP_FIXED, GRP_PROT
  } icp_group_e;

  typedef enum logic [3:0] {
    S_IDLE, S_CTRL, S_CACK, S_ADDR, S_AACK, S_WDATA, S_WACK,
    S_RDATA, S_RACK
  } icp_state_e;

endpackage

// *** sim/icp_i2c_config_port_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module icp_i2c_config_port_monitor (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       scl_i,
  input  wire logic       sda_o,
  input  wire logic       sda_oe,
  input  wire logic       por_restart_done,
  input  wire logic       por_restart_req,
  input  wire logic       outputs_frozen,
  input  wire logic [7:0] virtual_inputs,
  input  wire logic       cfg_wr_valid,
  input  wire logic [7:0] cfg_wr_addr,
  input  wire logic [7:0] cfg_wr_data
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ------------------------------------------------------------
  // Data pin drive
  // ------------------------------------------------------------
  property p_sda_low; sda_o == 1'b0; endproperty
  a_sda_low: assert property (p_sda_low)
    else $error("data pin driven high");
  property p_oe_scl_low; $changed(sda_oe) |-> !scl_i; endproperty
  a_oe_scl_low: assert property (p_oe_scl_low)
    else $error("data drive changed while clock high");
  // ------------------------------------------------------------
  // Write side effects
  // ------------------------------------------------------------
  property p_wr_pulse; cfg_wr_valid |=> !cfg_wr_valid; endproperty
  a_wr_pulse: assert property (p_wr_pulse)
    else $error("write strobe longer than one cycle");
  property p_wr_data; $changed(cfg_wr_data) |-> cfg_wr_valid; endproperty
  a_wr_data: assert property (p_wr_data)
    else $error("write data moved without strobe");
  property p_wr_addr; $changed(cfg_wr_addr) |-> cfg_wr_valid; endproperty
  a_wr_addr: assert property (p_wr_addr)
    else $error("write address moved without strobe");
  property p_vin; $changed(virtual_inputs) |-> !scl_i; endproperty
  a_vin: assert property (p_vin)
    else $error("virtual inputs changed outside acknowledge");
  property p_frz_on; $rose(outputs_frozen) |-> !scl_i; endproperty
  a_frz_on: assert property (p_frz_on)
    else $error("freeze began outside acknowledge");
  property p_frz_off; $fell(outputs_frozen) |-> scl_i; endproperty
  a_frz_off: assert property (p_frz_off)
    else $error("freeze ended outside stop");
  property p_req_on; $rose(por_restart_req) |-> !scl_i; endproperty
  a_req_on: assert property (p_req_on)
    else $error("restart request outside acknowledge");
  property p_req_off;
    $fell(por_restart_req) |-> $past(por_restart_done)
      || $past(por_restart_done, 2) || $past(por_restart_done, 3);
  endproperty
  a_req_off: assert property (p_req_off)
    else $error("restart request cleared without done");
endmodule
`default_nettype wire

// *** sim/icp_i2c_master_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module icp_i2c_master_model (
  input  wire logic clk,
  input  wire logic sda_in,
  output logic      scl,
  output logic      sda_pull
);
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  // Each clock phase lasts ten cycles, above the eight needed
  task automatic hold();
    repeat (10) @(negedge clk);
  endtask
  // Start or repeated start, data falls with clock high
  task automatic start();
    sda_pull = 1'b0;
    hold();
    scl = 1'b1;
    hold();
    sda_pull = 1'b1;
    hold();
    scl = 1'b0;
  endtask
  // Stop, data rises with clock high
  task automatic stop();
    sda_pull = 1'b1;
    hold();
    scl = 1'b1;
    hold();
    sda_pull = 1'b0;
    hold();
  endtask
  // Data moves only well after clock fall, sampled at clock high end
  task automatic bitx(input logic b, output logic r);
    repeat (2) @(negedge clk);
    sda_pull = ~b;
    hold();
    scl = 1'b1;
    hold();
    r = sda_in;
    scl = 1'b0;
  endtask
  // Byte out MSB first, ninth bit returns the acknowledge
  task automatic tx(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(d[i], r);
    bitx(1'b1, r);
    ack = ~r;
  endtask
  // Byte in, then own acknowledge asks for more
  task automatic rx(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(1'b1, r);
      d[i] = r;
    end
    bitx(~ack, r);
  endtask
endmodule
`default_nettype wire

// *** sim/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [7:0] CW = 8'hb0;
  localparam logic [7:0] CR = 8'hb1;
  logic        clk, reset_n, pull, scl, done_i, oe, fz, req, pdis, pen;
  logic [3:0]  pin, code, psel;
  logic [2:0]  pmode;
  logic [7:0]  vin, cnt_a;
  wire         sda = ~(pull | oe);
  int          miscompares, n_compared, cyc;
  icp_i2c_config_port i_dut (.clk(clk), .reset_n(reset_n), .scl_i(scl),
    .sda_i(sda), .sda_o(), .sda_oe(oe), .select_pin_lsb(pin[0]),
    .select_pin_second(pin[1]), .select_pin_third(pin[2]),
    .select_pin_msb(pin[3]), .nvm_control_code(code),
    .nvm_pin_select(psel), .nvm_port_disable(pdis),
    .nvm_prog_disable(1'b0), .nvm_code_compare(1'b0),
    .nvm_prot_enable(pen), .nvm_prot_mode(pmode),
    .live_values(56'h70605040302010), .counter_macrocell_wide(16'h1234),
    .counter_macrocell_a(cnt_a), .counter_macrocell_b(8'h78),
    .por_restart_done(done_i), .por_restart_req(req),
    .outputs_frozen(fz), .virtual_inputs(vin), .cfg_wr_valid(),
    .cfg_wr_addr(), .cfg_wr_data());
  icp_i2c_master_model i_master (.clk(clk), .sda_in(sda), .scl(scl),
    .sda_pull(pull));
  // Compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  // Send a byte and check the acknowledge
  task automatic sb(input logic [7:0] d, input logic e);
    logic k;
    i_master.tx(d, k);
    chk({7'h0, k}, {7'h0, e});
  endtask
  task automatic wr(input logic [7:0] a, d0, d1, input int n);
    i_master.start();
    sb(CW, 1'b1);
    sb(a, 1'b1);
    for (int i = 0; i < n; i++) sb(i ? d1 : d0, 1'b1);
    i_master.stop();
  endtask
  task automatic rdc(input logic [7:0] e0, e1, input int n);
    logic [7:0] d;
    i_master.start();
    sb(CR, 1'b1);
    for (int i = 0; i < n; i++) begin
      i_master.rx(i < n - 1, d);
      chk(d, i ? e1 : e0);
    end
    i_master.stop();
  endtask
  task automatic rd(input logic [7:0] a, e0, e1, input int n);
    i_master.start();
    sb(CW, 1'b1);
    sb(a, 1'b1);
    rdc(e0, e1, n);
  endtask
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // --------------------------------------------------------------
  // Clock and hang guard
  // --------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      miscompares++;
      final_report();
    end
  end
  // --------------------------------------------------------------
  // Test sequence
  // --------------------------------------------------------------
  initial begin
    reset_n = 1'b0;
    done_i = 1'b0;
    pin = 4'h0;
    code = 4'ha;
    psel = 4'h1;
    pdis = 1'b0;
    pen = 1'b1;
    pmode = 3'h0;
    cnt_a = 8'h56;
    repeat (10) @(negedge clk);
    reset_n = 1'b1;
    repeat (4) @(negedge clk);
    i_master.start();
    sb(CW, 1'b0);
    i_master.stop();
    pin = 4'h1;
    $display("test 1 done");
    wr(8'h4c, 8'h5a, 8'h00, 1);
    chk(vin, 8'h5a);
    rdc(8'h50, 8'h00, 1);
    $display("test 2 done");
    wr(8'h10, 8'h11, 8'h22, 2);
    rd(8'h10, 8'h11, 8'h22, 2);
    wr(8'ha7, 8'hff, 8'h00, 1);
    rd(8'ha5, 8'h34, 8'h12, 2);
    rd(8'ha7, 8'h56, 8'h78, 2);
    $display("test 3 done");
    wr(8'hf6, 8'h0f, 8'h00, 1);
    wr(8'h20, 8'hff, 8'h00, 1);
    rd(8'h20, 8'hf0, 8'h00, 1);
    rd(8'hf6, 8'h00, 8'h00, 1);
    $display("test 4 done");
    wr(8'hf5, 8'h02, 8'h00, 1);
    i_master.start();
    sb(CW, 1'b1);
    sb(8'h20, 1'b1);
    chk({7'h0, fz}, 8'h01);
    i_master.stop();
    chk({7'h0, fz}, 8'h00);
    wr(8'hf5, 8'h03, 8'h00, 1);
    chk({7'h0, req}, 8'h01);
    done_i = 1'b1;
    repeat (2) @(negedge clk);
    done_i = 1'b0;
    repeat (4) @(negedge clk);
    chk({7'h0, req}, 8'h00);
    rd(8'hf5, 8'h0a, 8'h00, 1);
    $display("test 5 done");
    wr(8'hf5, 8'ha0, 8'h00, 1);
    rd(8'hf5, 8'ha8, 8'h00, 1);
    wr(8'h20, 8'h00, 8'h00, 1);
    rd(8'h20, 8'hf0, 8'h00, 1);
    wr(8'hf5, 8'h00, 8'h00, 1);
    rd(8'hf5, 8'ha8, 8'h00, 1);
    rd(8'hfd, 8'h1a, 8'h00, 1);
    rd(8'h4c, 8'h5a, 8'h00, 1);
    $display("test 6 done");
    pen = 1'b0;
    wr(8'h60, 8'h77, 8'h00, 1);
    rd(8'hf5, 8'ha0, 8'h00, 1);
    i_master.start();
    sb(8'hb2, 1'b1);
    sb(8'h60, 1'b1);
    sb(8'h00, 1'b1);
    i_master.stop();
    pen = 1'b1;
    wr(8'h60, 8'h00, 8'h00, 1);
    rd(8'h60, 8'h77, 8'h00, 1);
    pdis = 1'b1;
    i_master.start();
    sb(CW, 1'b0);
    i_master.stop();
    pdis = 1'b0;
    $display("test 7 done");
    code = 4'hb;
    psel = 4'h0;
    pmode = 3'h6;
    reset_n = 1'b0;
    repeat (2) @(negedge clk);
    reset_n = 1'b1;
    repeat (4) @(negedge clk);
    rd(8'h48, 8'h00, 8'h00, 1);
    rd(8'hfd, 8'h0b, 8'h00, 1);
    rd(8'hf5, 8'hc8, 8'h00, 1);
    $display("test 8 done");
    final_report();
  end
endmodule
bind icp_i2c_config_port icp_i2c_config_port_monitor i_mon (.clk(clk),
  .reset_n(reset_n), .scl_i(scl_i), .sda_o(sda_o), .sda_oe(sda_oe),
  .por_restart_done(por_restart_done), .por_restart_req(por_restart_req),
  .outputs_frozen(outputs_frozen), .virtual_inputs(virtual_inputs),
  .cfg_wr_valid(cfg_wr_valid), .cfg_wr_addr(cfg_wr_addr),
  .cfg_wr_data(cfg_wr_data));
`default_nettype wire
